// >>> hdl/hssr_top.sv
// Digital side of a sampled Hall sensor: acquisition timing, filter,
// three-wire serial slave with chip select, trims and one-time storage.
// Assumes an analog front end and converter on clk_sys_i, and an external
// non-volatile store whose word is static after power-on.
module hssr_top
   import hssr_pkg::*;
#(
   parameter int unsigned TRACK2_CYC_P = TRACK2_CYC,
   parameter int unsigned HOLD2_CYC_P  = HOLD2_CYC
)(
   // System clock domain
   input  wire logic              clk_sys_i,
   input  wire logic              arst_n_i,
   input  wire logic              ce_i,
   // Serial link pins
   input  wire logic              sck_i,
   input  wire logic              cs_n_i,
   input  wire logic              serial_in_i,
   output logic                   serial_out_o,
   output logic                   serial_oe_n_o,
   // Analog front end and converter
   output logic                   s1_hold_o,
   output logic                   s2_track_o,
   output logic                   conv_start_o,
   input  wire logic              adc_valid_i,
   input  wire logic [WORD_W-1:0] adc_diff_i,
   // Trim settings
   output logic [FSEL_W-1:0]      filt_sel_o,
   output logic [GAIN_W-1:0]      gain_trim_o,
   // One-time programmable store
   input  wire logic [OTP_W-1:0]  otp_rdata_i,
   output logic                   otp_prog_o,
   output logic [OTP_W-1:0]       otp_wdata_o
);
   localparam logic [TMR_W-1:0] T2_END = TMR_W'(TRACK2_CYC_P - 1);
   localparam logic [TMR_W-1:0] T3_END = TMR_W'(HOLD2_CYC_P - 1);

   typedef enum logic [1:0] {
      ACQ_IDLE   = 2'b00,  // Tracking first sample
      ACQ_HOLD1  = 2'b01,  // First sample held
      ACQ_TRACK2 = 2'b10,  // Second sample tracking
      ACQ_CONV   = 2'b11   // Both held, converting
   } hssr_acq_e;

   // Link domain
   logic                  lnk_rst;     // Deselect or power-on reset
   logic                  fresh_reg;   // Frame already started
   logic [FRAME_BITS-1:0] rx_sh_reg;   // Received bits
   logic [4:0]            rx_cnt_reg;  // Received bit count

   // Synchronisers and edges
   logic                  cs_s1, cs_q, cs_d;
   logic                  sck_s1, sck_q, sck_d;
   logic [OTP_W-1:0]      otp_s1, otp_q;
   logic                  cs_fall, cs_rise, sck_fall;

   // System domain state
   hssr_acq_e             acq_reg;     // Acquisition phase
   logic [TMR_W-1:0]      tmr_reg;     // Time since select fall
   logic [WORD_W-1:0]     code;        // Offset binary sample
   logic                  flt_valid;   // Filter output strobe
   logic [WORD_W-1:0]     flt_y;       // Filter output
   logic [WORD_W-1:0]     result_reg;  // Latest conversion result
   logic [WORD_W-1:0]     io_word_reg; // Word being shifted out
   logic [3:0]            bit_idx_reg; // Next bit to present
   logic                  wr_take;     // Valid write frame ended
   logic                  arm_reg;     // Programming pending
   logic [OTP_W-1:0]      prog_val_reg;// Value to burn
   logic [1:0]            boot_reg;    // Boot load counter

   // Bits are shifted in on rising serial clock; frame resets on deselect
   assign lnk_rst = cs_n_i | ~arst_n_i;

   // Marks the first clock of a frame without clearing received bits,
   // so the word stays stable while the system side picks it up
   always_ff @(posedge sck_i or posedge lnk_rst) begin
      if (lnk_rst) begin
         fresh_reg <= 1'b0;
      end else begin
         fresh_reg <= 1'b1;
      end
   end

   // Shift register and saturating count
   always_ff @(posedge sck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_sh_reg  <= '0;
         rx_cnt_reg <= '0;
      end else if (cs_n_i) begin
         rx_sh_reg  <= rx_sh_reg;
      end else if (!fresh_reg) begin
         rx_sh_reg  <= {{(FRAME_BITS-1){1'b0}}, serial_in_i};
         rx_cnt_reg <= 5'h01;
      end else begin
         rx_sh_reg  <= {rx_sh_reg[FRAME_BITS-2:0], serial_in_i};
         if (rx_cnt_reg != CNT_MAX) begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
         end
      end
   end

   // Two-stage synchronisers for pins and the storage word
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_s1  <= 1'b1;
         cs_q   <= 1'b1;
         sck_s1 <= 1'b0;
         sck_q  <= 1'b0;
         otp_s1 <= '0;
         otp_q  <= '0;
      end else begin
         cs_s1  <= cs_n_i;
         cs_q   <= cs_s1;
         sck_s1 <= sck_i;
         sck_q  <= sck_s1;
         otp_s1 <= otp_rdata_i;
         otp_q  <= otp_s1;
      end
   end

   // Edge history, frozen with the enable
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_d  <= 1'b1;
         sck_d <= 1'b0;
      end else if (ce_i) begin
         cs_d  <= cs_q;
         sck_d <= sck_q;
      end
   end

   assign cs_fall  = cs_d & ~cs_q;
   assign cs_rise  = ~cs_d & cs_q;
   assign sck_fall = sck_d & ~sck_q & ~cs_q;

   // Acquisition sequence, paced only by select falls
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acq_reg      <= ACQ_IDLE;
         tmr_reg      <= '0;
         s1_hold_o    <= 1'b0;
         s2_track_o   <= 1'b0;
         conv_start_o <= 1'b0;
      end else if (ce_i) begin
         conv_start_o <= 1'b0;
         if (cs_fall) begin
            // A new fall restarts the pair even mid-conversion
            acq_reg    <= ACQ_HOLD1;
            tmr_reg    <= '0;
            s1_hold_o  <= 1'b1;
            s2_track_o <= 1'b0;
         end else begin
            unique case (acq_reg)
               ACQ_IDLE: begin
                  s1_hold_o <= 1'b0;
               end
               ACQ_HOLD1: begin
                  tmr_reg <= tmr_reg + 16'h0001;
                  if (tmr_reg == T2_END) begin
                     acq_reg    <= ACQ_TRACK2;
                     s2_track_o <= 1'b1;
                  end
               end
               ACQ_TRACK2: begin
                  tmr_reg <= tmr_reg + 16'h0001;
                  if (tmr_reg == T3_END) begin
                     acq_reg      <= ACQ_CONV;
                     s2_track_o   <= 1'b0;
                     conv_start_o <= 1'b1;
                  end
               end
               ACQ_CONV: begin
                  if (adc_valid_i) begin
                     acq_reg   <= ACQ_IDLE;
                     s1_hold_o <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // Signed difference to offset binary: zero field sits mid-scale
   assign code = {~adc_diff_i[WORD_W-1], adc_diff_i[WORD_W-2:0]};

   hssr_ewma u_ewma (
      .clk_i       (clk_sys_i),
      .arst_n_i    (arst_n_i),
      .ce_i        (ce_i),
      .sel_i       (filt_sel_o),
      .in_valid_i  (acq_reg == ACQ_CONV && adc_valid_i && !cs_fall),
      .x_i         (code),
      .out_valid_o (flt_valid),
      .y_o         (flt_y)
   );

   // Result waits here until the next select fall
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         result_reg <= '0;
      end else if (ce_i && flt_valid) begin
         result_reg <= flt_y;
      end
   end

   // Output shifter: MSB presented at select fall, next bit per falling
   // serial clock; zeros after the word
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         io_word_reg  <= '0;
         bit_idx_reg  <= IDX_DONE;
         serial_out_o <= 1'b0;
      end else if (ce_i) begin
         if (cs_fall) begin
            io_word_reg  <= result_reg;
            serial_out_o <= result_reg[WORD_W-1];
            bit_idx_reg  <= MSB_IDX - 4'h1;
         end else if (sck_fall) begin
            if (bit_idx_reg == IDX_DONE) begin
               serial_out_o <= 1'b0;
            end else begin
               serial_out_o <= io_word_reg[bit_idx_reg];
               bit_idx_reg  <= bit_idx_reg - 4'h1;
            end
         end
      end
   end

   // Drive enable follows select; released on deselect
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         serial_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         serial_oe_n_o <= cs_q;
      end
   end

   // Received word is quiet once select is high; read at synced rise
   assign wr_take = cs_rise && rx_cnt_reg >= FRAME_CNT
                    && rx_sh_reg[HDR_MSB:HDR_LSB] == WR_HDR;

   // Trim settings: boot load from storage, then write frames
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_reg    <= '0;
         filt_sel_o  <= '0;
         gain_trim_o <= '0;
      end else if (ce_i) begin
         if (boot_reg != BOOT_CYC + 2'h1) begin
            // Synchroniser is cleared by reset, so wait until it holds the word
            boot_reg <= boot_reg + 2'h1;
            if (boot_reg == BOOT_CYC) begin
               {filt_sel_o, gain_trim_o} <= otp_q;
            end
         end else if (wr_take) begin
            filt_sel_o  <= rx_sh_reg[FSEL_MSB:FSEL_LSB];
            gain_trim_o <= rx_sh_reg[GAIN_MSB:GAIN_LSB];
         end
      end
   end

   // Program bit arms a pulse at the following select fall; storage only
   // ever sets ones, so a burn cannot be undone
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         arm_reg      <= 1'b0;
         prog_val_reg <= '0;
         otp_prog_o   <= 1'b0;
         otp_wdata_o  <= '0;
      end else if (ce_i) begin
         otp_prog_o <= 1'b0;
         if (cs_fall && arm_reg) begin
            arm_reg     <= 1'b0;
            otp_prog_o  <= 1'b1;
            otp_wdata_o <= prog_val_reg;
         end else if (wr_take && rx_sh_reg[PROG_POS]) begin
            arm_reg      <= 1'b1;
            prog_val_reg <= rx_sh_reg[FSEL_MSB:GAIN_LSB];
         end
      end
   end

   a_hold1_at_fall : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && cs_fall |=> s1_hold_o && !s2_track_o)
      else $error("first sample not held after select fall");

   a_track2_start : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && !cs_fall && acq_reg == ACQ_HOLD1 && tmr_reg == T2_END
      |=> s2_track_o && acq_reg == ACQ_TRACK2)
      else $error("second sample tracking did not start on time");

   a_conv_pulse : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      $rose(conv_start_o) |-> !s2_track_o && s1_hold_o ##1 !conv_start_o)
      else $error("conversion start not a single pulse after hold");

   a_load_at_fall : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && cs_fall |=> io_word_reg == $past(result_reg)
      && serial_out_o == $past(result_reg[WORD_W-1]))
      else $error("output word not loaded at select fall");

   a_zero_code : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      adc_diff_i == 12'h000 |-> code == 12'h800)
      else $error("zero difference not at mid-scale code");

   a_oe_follows_cs : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && cs_q |=> serial_oe_n_o)
      else $error("serial output driven while deselected");

   a_out_stable : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && !cs_fall && !sck_fall |=> $stable(serial_out_o))
      else $error("serial output changed without a falling serial clock");

   a_write_apply : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && wr_take && boot_reg == BOOT_CYC + 2'h1
      |=> filt_sel_o == $past(rx_sh_reg[FSEL_MSB:FSEL_LSB]))
      else $error("write frame did not set filter select");

   a_otp_fire : assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      ce_i && arm_reg && cs_fall |=> otp_prog_o ##1 !otp_prog_o)
      else $error("programming pulse missing at select fall");
endmodule : hssr_top

// >>> hdl/hssr_pkg.sv
// Shared constants of the Hall sensor serial readout block.
// Assumes a 200 MHz system clock; serial clock is a separate domain.
package hssr_pkg;
   // System clock rate
   localparam int unsigned SYS_MHZ     = 200;
   // Acquisition timing from chip select fall, in microseconds
   localparam int unsigned TRACK2_US   = 32;
   localparam int unsigned HOLD2_US    = 96;
   // Derived cycle counts (defaults of top-level parameters)
   localparam int unsigned TRACK2_CYC  = TRACK2_US * SYS_MHZ;
   localparam int unsigned HOLD2_CYC   = HOLD2_US * SYS_MHZ;
   localparam int unsigned TMR_W       = 16;
   // Sample word
   localparam int unsigned WORD_W      = 12;
   localparam logic [3:0]  MSB_IDX     = 4'hb;
   localparam logic [3:0]  IDX_DONE    = 4'hf;
   // Filter select and gain trim widths, filter fraction bits
   localparam int unsigned FSEL_W      = 3;
   localparam int unsigned GAIN_W      = 6;
   localparam int unsigned FRAC_W      = 7;
   localparam int unsigned OTP_W       = FSEL_W + GAIN_W;
   // Write frame layout, first bit received ends up at the top
   localparam int unsigned FRAME_BITS  = 16;
   localparam logic [4:0]  FRAME_CNT   = 5'h10;
   localparam logic [4:0]  CNT_MAX     = 5'h1f;
   localparam logic [1:0]  WR_HDR      = 2'h2;
   localparam int unsigned HDR_MSB     = 15;
   localparam int unsigned HDR_LSB     = 14;
   localparam int unsigned FSEL_MSB    = 13;
   localparam int unsigned FSEL_LSB    = 11;
   localparam int unsigned GAIN_MSB    = 10;
   localparam int unsigned GAIN_LSB    = 5;
   localparam int unsigned PROG_POS    = 0;
   // Boot: cycles before the synchronised storage word is trusted
   localparam logic [1:0]  BOOT_CYC    = 2'h2;
endpackage : hssr_pkg

// >>> hdl/hssr_ewma.sv
// Exponentially weighted moving average filter for one 12-bit stream.
// Assumes one input strobe per sampling interval on the system clock.
module hssr_ewma
   import hssr_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              arst_n_i,
   input  wire logic              ce_i,
   // Setting and sample in
   input  wire logic [FSEL_W-1:0] sel_i,
   input  wire logic              in_valid_i,
   input  wire logic [WORD_W-1:0] x_i,
   // Filtered sample out
   output logic                   out_valid_o,
   output logic [WORD_W-1:0]      y_o
);
   localparam int unsigned ACC_W = WORD_W + FRAC_W;

   logic [ACC_W-1:0] acc_reg;   // Previous output with fraction bits
   logic [ACC_W:0]   diff;      // Signed step towards new sample
   logic [ACC_W-1:0] acc_next;  // Updated accumulator

   // Weight is 2^-sel; fraction bits keep the slow settings from stalling
   always_comb begin
      diff     = {1'b0, x_i, {FRAC_W{1'b0}}} - {1'b0, acc_reg};
      acc_next = acc_reg + ACC_W'($signed(diff) >>> sel_i);
   end

   // State starts at zero and survives a change of setting
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acc_reg <= '0;
      end else if (ce_i && in_valid_i) begin
         acc_reg <= acc_next;
      end
   end

   // One output per input strobe
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_valid_o <= 1'b0;
      end else if (ce_i) begin
         out_valid_o <= in_valid_i;
      end
   end

   assign y_o = acc_reg[ACC_W-1:FRAC_W];

   a_filter_bypass : assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ce_i && in_valid_i && sel_i == 3'h0 |=> y_o == $past(x_i))
      else $error("unfiltered setting did not pass sample through");
endmodule : hssr_ewma

// >>> bench/hssr_master.sv
// Serial master model for the Hall sensor readout: select, clock, data in.
// Assumes a free 32 ns link clock; the serial clock it makes runs in frames.
module hssr_master (
   // Link clock
   input  wire logic clk_link_i,
   // From the device
   input  wire logic sdo_i,
   input  wire logic oe_n_i,
   // To the device
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      sdi_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int oe_bad;  // Bits seen while the device was not driving

   // Idle: deselected, serial clock low
   initial begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      sdi_o  = 1'b0;
      oe_bad = 0;
   end

   // Wait whole link cycles
   task automatic wait_link(input int n);
      repeat (n) @(posedge clk_link_i);
   endtask : wait_link

   // One framed transfer, first bit sent is wbits[nbits-1]
   task automatic frame(input int nbits, input logic [15:0] wbits, output logic [15:0] rbits);
      rbits = 16'h0000;
      @(posedge clk_link_i);
      cs_n_o <= 1'b0;
      wait_link(4);                 // Over 100 ns before first rise
      for (int i = nbits - 1; i >= 0; i--) begin
         sdi_o <= wbits[i];
         wait_link(8);
         sck_o <= 1'b1;
         rbits[i] = sdo_i;
         if (oe_n_i !== 1'b0) begin
            oe_bad++;
         end
         wait_link(8);
         sck_o <= 1'b0;
      end
      wait_link(3);                 // Over 50 ns after last fall
      cs_n_o <= 1'b1;
      sdi_o  <= ~sdi_o;             // Line no longer holds the last bit
      wait_link(4);
   endtask : frame

   // Clock and data wiggle while deselected, must be ignored
   task automatic noise();
      repeat (20) begin
         wait_link(2);
         sck_o <= ~sck_o;
         sdi_o <= ~sdi_o;
      end
   endtask : noise
endmodule : hssr_master

// >>> bench/test_hssr_top.sv
// Self-checking bench of the Hall sensor readout, with a master model.
// Assumes shortened acquisition counts and a converter model on clk_sys_i.
module test_hssr_top;
   import hssr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned T2 = 20;  // Second track start, cycles
   localparam int unsigned H2 = 60;  // Second hold, cycles

   // Design ports
   logic              clk_sys_i, clk_link, arst_n_i, adc_valid_i, ce_i;
   logic [15:0]       rd16;
   logic [WORD_W-1:0] adc_diff_i;
   logic [OTP_W-1:0]  otp_rdata_i, otp_wdata_o, prog_data;
   logic              sck, cs_n, serial_in, serial_out_o, serial_oe_n_o;
   logic              s1_hold_o, s2_track_o, conv_start_o, otp_prog_o;
   logic [FSEL_W-1:0] filt_sel_o;
   logic [GAIN_W-1:0] gain_trim_o;
   // Bench state
   logic              sdo_last, sdo_w, cs_q, h_q, t_q;
   logic [11:0]       exp_word, diff_q, code;
   int                mismatches, samples_checked, tcs, t_h, t_tr, t_cv, cd, prog_cnt;
   int                acc, cur_sel;

   hssr_top #(.TRACK2_CYC_P(T2), .HOLD2_CYC_P(H2)) hssr_top_i (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
      .sck_i(sck), .cs_n_i(cs_n), .serial_in_i(serial_in),
      .serial_out_o(serial_out_o), .serial_oe_n_o(serial_oe_n_o),
      .s1_hold_o(s1_hold_o), .s2_track_o(s2_track_o), .conv_start_o(conv_start_o),
      .adc_valid_i(adc_valid_i), .adc_diff_i(adc_diff_i),
      .filt_sel_o(filt_sel_o), .gain_trim_o(gain_trim_o),
      .otp_rdata_i(otp_rdata_i), .otp_prog_o(otp_prog_o), .otp_wdata_o(otp_wdata_o));

   hssr_master hssr_master_i (.clk_link_i(clk_link), .sdo_i(sdo_w), .oe_n_i(serial_oe_n_o),
      .sck_o(sck), .cs_n_o(cs_n), .sdi_o(serial_in));

   // Released line shows the inverse, not a kind stale bit
   always @* if (serial_oe_n_o === 1'b0) sdo_last = serial_out_o;
   assign sdo_w = (serial_oe_n_o === 1'b0) ? serial_out_o : ~sdo_last;

   // Clocks, unrelated in phase
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      clk_link = 1'b0;
      #7.3;
      forever #16 clk_link = ~clk_link;
   end

   // Event times counted from the select fall
   always @(posedge clk_sys_i) begin
      cs_q <= cs_n;
      h_q  <= s1_hold_o;
      t_q  <= s2_track_o;
      tcs  <= (cs_q && !cs_n) ? 0 : tcs + 1;
      if (s1_hold_o && !h_q) t_h <= tcs;
      if (s2_track_o && !t_q) t_tr <= tcs;
      if (conv_start_o) t_cv <= tcs;
      if (otp_prog_o) begin
         prog_cnt  <= prog_cnt + 1;
         prog_data <= otp_wdata_o;
      end
   end

   // Converter: answers 5 cycles after start; expected filter output kept here
   always @(posedge clk_sys_i) begin
      #1;
      adc_valid_i = 1'b0;
      if (cd == 0) begin
         adc_valid_i = 1'b1;
         adc_diff_i  = diff_q;
         code        = diff_q + 12'h800;
         acc         = acc + ((int'(code) * 128 - acc) >>> cur_sel);
         exp_word    = 12'(acc >>> 7);
      end
      if (conv_start_o === 1'b1) cd = 4;
      else if (cd >= 0) cd = cd - 1;
   end

   // Compare and count
   task automatic chk(input string name, input logic [31:0] want, input logic [31:0] got);
      samples_checked++;
      if (got !== want) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, want, got);
      end
   endtask : chk

   // One frame; the word read is the previous interval's result
   task automatic xfer(input int n, input logic [15:0] w, input logic [11:0] d);
      logic [11:0] want;
      logic [15:0] r;
      want   = exp_word;
      diff_q = d;
      hssr_master_i.frame(n, w, r);
      chk("read word", 32'(want), 32'((r >> (n - 12)) & 16'h0fff));
      repeat (6) @(posedge clk_sys_i);
      chk("oe idle", 32'h1, 32'(serial_oe_n_o));
      chk("oe in frame", 32'h0, 32'(hssr_master_i.oe_bad));
   endtask : xfer

   // Reset with a given stored word, then boot load
   task automatic do_reset(input logic [OTP_W-1:0] w);
      @(posedge clk_sys_i);
      #1;
      otp_rdata_i = w;
      arst_n_i    = 1'b0;
      acc         = 0;
      exp_word    = 12'h000;
      cur_sel     = int'(w[8:6]);
      repeat (20) @(posedge clk_sys_i);
      chk("reset state", 32'h400000, 32'({serial_oe_n_o, s1_hold_o, s2_track_o,
          conv_start_o, filt_sel_o, gain_trim_o, otp_prog_o, otp_wdata_o}));
      #1 arst_n_i = 1'b1;
      repeat (5) @(posedge clk_sys_i);
      chk("boot trims", 32'(w), 32'({filt_sel_o, gain_trim_o}));
   endtask : do_reset

   // Verdict, single exit
   task automatic end_of_test();
      if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   // Hang guard, well past the expected run
   initial begin
      #400us;
      mismatches++;
      end_of_test();
   end

   // Main sequence
   initial begin
      arst_n_i = 1'b0; otp_rdata_i = 9'h000; adc_valid_i = 1'b0; adc_diff_i = 12'h000;
      ce_i = 1'b1;
      diff_q = 12'h000; cd = -1; prog_cnt = 0; cs_q = 1'b1; sdo_last = 1'b0;
      mismatches = 0; samples_checked = 0; tcs = 0;
      do_reset({3'h0, 6'h25});
      xfer(12, 16'h0000, 12'h100);
      xfer(12, 16'h0000, 12'hc00);
      chk("first hold", 32'h1, 32'(t_h >= 1 && t_h <= 4));
      chk("second track", 32'h1, 32'(t_tr >= T2 && t_tr <= T2 + 5));
      chk("second hold", 32'(H2 - T2), 32'(t_cv - t_tr));
      hssr_master_i.noise();
      chk("idle ignored", 32'h025, 32'({filt_sel_o, gain_trim_o}));
      // Enable low freezes the system side: the write is lost, nothing driven
      @(posedge clk_sys_i);
      #1 ce_i = 1'b0;
      hssr_master_i.frame(16, 16'h9fe0, rd16);
      chk("frozen oe", 32'h10, 32'(hssr_master_i.oe_bad));
      @(posedge clk_sys_i);
      #1 ce_i = 1'b1;
      hssr_master_i.oe_bad = 0;
      repeat (6) @(posedge clk_sys_i);
      chk("frozen trims", 32'h025, 32'({filt_sel_o, gain_trim_o}));
      xfer(16, 16'h9200, 12'h100);
      chk("preview trims", 32'h090, 32'({filt_sel_o, gain_trim_o}));
      cur_sel = 2;
      xfer(15, 16'h5ff0, 12'h300);
      chk("short frame", 32'h090, 32'({filt_sel_o, gain_trim_o}));
      xfer(12, 16'h0000, 12'h300);
      xfer(12, 16'h0000, 12'h300);
      xfer(16, 16'h8181, 12'h300);
      chk("no early burn", 32'h0, 32'(prog_cnt));
      chk("program trims", 32'h00c, 32'({filt_sel_o, gain_trim_o}));
      cur_sel = 0;
      xfer(16, 16'h0000, 12'h000);
      chk("burn count", 32'h1, 32'(prog_cnt));
      chk("burn data", 32'h00c, 32'(prog_data));
      do_reset({3'h2, 6'h0a});
      xfer(12, 16'h0000, 12'h000);
      end_of_test();
   end
endmodule : test_hssr_top
